// >>> logic/gcfs_pkg.sv
// Purpose: Shared constants for the rate sensor configuration register bank
// Assumes: Byte-wide register port, one clock
// Notes:   Offsets are the printed register addresses
`default_nettype none
package gcfs_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          WORD_W          = 16;
    localparam int          NUM_CHAN        = 4;
    // Register offsets
    localparam logic [7:0]  OFS_DIVIDER     = 8'h19;
    localparam logic [7:0]  OFS_LOWPASS     = 8'h1a;
    localparam logic [7:0]  OFS_RATE_SETUP  = 8'h1b;
    localparam logic [7:0]  OFS_LP_CYCLE    = 8'h1e;
    localparam logic [7:0]  OFS_CHAN_SEL    = 8'h23;
    localparam logic [7:0]  OFS_SYNC_FLAG   = 8'h36;
    localparam logic [7:0]  OFS_SYNC_CFG    = 8'h37;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h70;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h71;
    // Writable bits per register; the rest read as zero
    localparam logic [7:0]  MSK_DIVIDER     = 8'hff;
    localparam logic [7:0]  MSK_LOWPASS     = 8'h07;
    localparam logic [7:0]  MSK_RATE_SETUP  = 8'hfb;
    localparam logic [7:0]  MSK_LP_CYCLE    = 8'hf0;
    localparam logic [7:0]  MSK_CHAN_SEL    = 8'hf0;
    localparam logic [7:0]  MSK_SYNC_CFG    = 8'h0c;
    localparam logic [7:0]  MSK_IRQ         = 8'h03;
    // Reset values
    localparam logic [7:0]  RST_REG         = 8'h00;
    // Field positions
    localparam int          X_SELFTEST_BIT  = 7;
    localparam int          Y_SELFTEST_BIT  = 6;
    localparam int          Z_SELFTEST_BIT  = 5;
    localparam int          FSR_HI          = 4;
    localparam int          FSR_LO          = 3;
    localparam int          BYPASS_HI       = 1;
    localparam int          BYPASS_LO       = 0;
    localparam int          LP_CYCLE_BIT    = 7;
    localparam int          AVG_HI          = 6;
    localparam int          AVG_LO          = 4;
    localparam int          LOWPASS_HI      = 2;
    localparam int          LOWPASS_LO      = 0;
    localparam int          CHAN_TOP_BIT    = 7;
    localparam int          SYNC_FLAG_BIT   = 7;
    localparam int          SYNC_LEVEL_BIT  = 3;
    localparam int          SYNC_EN_BIT     = 2;
    localparam int          IRQ_SYNC_BIT    = 0;
    localparam int          IRQ_SAMPLE_BIT  = 1;
    // Filter bypass code that lets the low-pass setting apply
    localparam logic [1:0]  BYPASS_NONE     = 2'b00;
    // Full-scale codes: 250, 500, 1000, 2000 deg/s
    localparam logic [1:0]  FSR_250         = 2'b00;
    localparam logic [1:0]  FSR_2000        = 2'b11;
    // Timing
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          BASE_RATE_HZ    = 1000;
    localparam int          BASE_TICK_CYC   = CLK_HZ / BASE_RATE_HZ;

    typedef enum logic [1:0] {
        PUSH_IDLE,
        PUSH_HIGH,
        PUSH_LOW
    } gcfs_push_t;
endpackage
`default_nettype wire

// >>> logic/gcfs_sample_tick.sv
// Purpose: Sample-rate strobe from the 1 kHz base rate and a divider
// Assumes: Divider comes from a register on the same clock
// Notes:   A new divider value takes effect at the next base tick
`timescale 1ns/1ps
`default_nettype none
module gcfs_sample_tick #(
    parameter int BASE_CYC = gcfs_pkg::BASE_TICK_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] divider,
    output var  logic       tick_r
);
    logic [31:0] base_cnt_r;
    logic [31:0] base_cnt_nxt;
    logic [7:0]  div_cnt_r;
    logic [7:0]  div_cnt_nxt;
    logic        tick_nxt;

    always_comb begin
        base_cnt_nxt = base_cnt_r + 32'h1;
        div_cnt_nxt  = div_cnt_r;
        tick_nxt     = 1'b0;
        if (base_cnt_r >= 32'(BASE_CYC - 1)) begin
            base_cnt_nxt = 32'h0;
            if (div_cnt_r >= divider) begin
                div_cnt_nxt = 8'h00;
                tick_nxt    = 1'b1;
            end else begin
                div_cnt_nxt = div_cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            base_cnt_r <= 32'h0;
            div_cnt_r  <= 8'h00;
            tick_r     <= 1'b0;
        end else begin
            base_cnt_r <= base_cnt_nxt;
            div_cnt_r  <= div_cnt_nxt;
            tick_r     <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> logic/gcfs_regs.sv
// Purpose: Rate sensor setup, low-power cycling, channel selection, sync flag
// Assumes: Sample words come from logic on ref_clk; sync pin is asynchronous
// Notes:   Byte stream out has no back-pressure; the buffer behind must absorb it
// Function
// - Full-scale range from setup bits 4:3
// - Bypass field bits 1:0 controls low-pass use
// - Cycling bit 7 enables low-power, resets zero
// - Averaging depth bits 6:4, doubling 1x-128x
// - Low-power ignores the low-pass setting
// - Temperature high then low byte pushed
// - Bits 6..4 push X, Y, Z bytes
// - Push even when data path idles
// - Sync event sets flag bit 7
// - Reading flag register clears it
// - Sync event on transition to active level
// - Strobe is 1 kHz over divider plus one
// - Low-pass setting applies only with bypass 00
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module gcfs_regs #(
    parameter int BASE_CYC = gcfs_pkg::BASE_TICK_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        frame_sync_pin,
    input  wire logic [15:0] temp_word,
    input  wire logic [15:0] x_rate_word,
    input  wire logic [15:0] y_rate_word,
    input  wire logic [15:0] z_rate_word,
    output var  logic [2:0]  selftest_xyz,
    output var  logic [1:0]  full_scale_range_select,
    output var  logic [1:0]  filter_bypass_choice,
    output var  logic        lowpass_filter_active,
    output var  logic [2:0]  lowpass_filter_setting,
    output var  logic        low_power_mode,
    output var  logic [2:0]  averaging_depth_setting,
    output var  logic        sample_strobe,
    output var  logic        push_valid,
    output var  logic [7:0]  push_byte,
    output var  logic        irq
);
    logic [7:0]  divider_r, divider_nxt;
    logic [7:0]  lowpass_r, lowpass_nxt;
    logic [7:0]  setup_r, setup_nxt;
    logic [7:0]  lp_cycle_r, lp_cycle_nxt;
    logic [7:0]  chan_sel_r, chan_sel_nxt;
    logic [7:0]  sync_cfg_r, sync_cfg_nxt;
    logic        sync_flag_r, sync_flag_nxt;
    logic [1:0]  irq_stat_r, irq_stat_nxt;
    logic [1:0]  irq_mask_r, irq_mask_nxt;
    logic        irq_r, irq_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        lp_active_r, lp_active_nxt;
    logic        sync_meta_r, sync_s_r, sync_prev_r;
    logic        sync_evt;
    logic        tick;
    gcfs_pkg::gcfs_push_t state_r, state_nxt;
    logic [3:0]  pend_r, pend_nxt;
    logic [1:0]  chan_r, chan_nxt;
    logic [15:0] word_r [4];
    logic [15:0] word_nxt [4];
    logic        pv_r, pv_nxt;
    logic [7:0]  pb_r, pb_nxt;

    function automatic logic [1:0] first_chan(input logic [3:0] m);
        logic [1:0] c;
        c = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (m[3 - i]) begin
                c = 2'(i);
            end
        end
        return c;
    endfunction

    gcfs_sample_tick #(
        .BASE_CYC (BASE_CYC)
    ) u_tick (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .divider  (divider_r),
        .tick_r   (tick)
    );

    // Pin crosses two flip-flops before the edge logic looks at it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_meta_r <= 1'b0;
            sync_s_r    <= 1'b0;
            sync_prev_r <= 1'b0;
        end else begin
            sync_meta_r <= frame_sync_pin;
            sync_s_r    <= sync_meta_r;
            sync_prev_r <= sync_s_r;
        end
    end

    always_comb begin
        sync_evt = sync_cfg_r[gcfs_pkg::SYNC_EN_BIT]
                 & (sync_s_r ^ sync_cfg_r[gcfs_pkg::SYNC_LEVEL_BIT])
                 & ~(sync_prev_r ^ sync_cfg_r[gcfs_pkg::SYNC_LEVEL_BIT]);
    end

    // Register file
    always_comb begin
        divider_nxt  = divider_r;
        lowpass_nxt  = lowpass_r;
        setup_nxt    = setup_r;
        lp_cycle_nxt = lp_cycle_r;
        chan_sel_nxt = chan_sel_r;
        sync_cfg_nxt = sync_cfg_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        sync_flag_nxt = sync_flag_r;
        rdata_nxt    = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                gcfs_pkg::OFS_DIVIDER:    divider_nxt  = reg_wdata & gcfs_pkg::MSK_DIVIDER;
                gcfs_pkg::OFS_LOWPASS:    lowpass_nxt  = reg_wdata & gcfs_pkg::MSK_LOWPASS;
                gcfs_pkg::OFS_RATE_SETUP: setup_nxt    = reg_wdata & gcfs_pkg::MSK_RATE_SETUP;
                gcfs_pkg::OFS_LP_CYCLE:   lp_cycle_nxt = reg_wdata & gcfs_pkg::MSK_LP_CYCLE;
                gcfs_pkg::OFS_CHAN_SEL:   chan_sel_nxt = reg_wdata & gcfs_pkg::MSK_CHAN_SEL;
                gcfs_pkg::OFS_SYNC_CFG:   sync_cfg_nxt = reg_wdata & gcfs_pkg::MSK_SYNC_CFG;
                gcfs_pkg::OFS_IRQ_MASK:   irq_mask_nxt = reg_wdata[1:0];
                gcfs_pkg::OFS_IRQ_STAT:   irq_stat_nxt = irq_stat_r & ~reg_wdata[1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                gcfs_pkg::OFS_DIVIDER:    rdata_nxt = divider_r;
                gcfs_pkg::OFS_LOWPASS:    rdata_nxt = lowpass_r;
                gcfs_pkg::OFS_RATE_SETUP: rdata_nxt = setup_r;
                gcfs_pkg::OFS_LP_CYCLE:   rdata_nxt = lp_cycle_r;
                gcfs_pkg::OFS_CHAN_SEL:   rdata_nxt = chan_sel_r;
                gcfs_pkg::OFS_SYNC_CFG:   rdata_nxt = sync_cfg_r;
                gcfs_pkg::OFS_IRQ_MASK:   rdata_nxt = {6'h00, irq_mask_r};
                gcfs_pkg::OFS_IRQ_STAT:   rdata_nxt = {6'h00, irq_stat_r};
                gcfs_pkg::OFS_SYNC_FLAG: begin
                    rdata_nxt = {sync_flag_r, 7'h00};
                    sync_flag_nxt = 1'b0;
                end
                default: ;
            endcase
        end
        if (sync_evt) begin
            sync_flag_nxt = 1'b1;
        end
        // Events set after the write-one clear so a coincident event stays
        if (sync_evt) begin
            irq_stat_nxt[gcfs_pkg::IRQ_SYNC_BIT] = 1'b1;
        end
        if (tick) begin
            irq_stat_nxt[gcfs_pkg::IRQ_SAMPLE_BIT] = 1'b1;
        end
        irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
        // Low-pass only outside cycling and with no bypass
        lp_active_nxt = ~lp_cycle_nxt[gcfs_pkg::LP_CYCLE_BIT]
                      & (setup_nxt[gcfs_pkg::BYPASS_HI:gcfs_pkg::BYPASS_LO]
                         == gcfs_pkg::BYPASS_NONE);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            divider_r   <= gcfs_pkg::RST_REG;
            lowpass_r   <= gcfs_pkg::RST_REG;
            setup_r     <= gcfs_pkg::RST_REG;
            lp_cycle_r  <= gcfs_pkg::RST_REG;
            chan_sel_r  <= gcfs_pkg::RST_REG;
            sync_cfg_r  <= gcfs_pkg::RST_REG;
            sync_flag_r <= 1'b0;
            irq_stat_r  <= 2'b00;
            irq_mask_r  <= 2'b00;
            irq_r       <= 1'b0;
            rdata_r     <= 8'h00;
            lp_active_r <= 1'b1;
        end else begin
            divider_r   <= divider_nxt;
            lowpass_r   <= lowpass_nxt;
            setup_r     <= setup_nxt;
            lp_cycle_r  <= lp_cycle_nxt;
            chan_sel_r  <= chan_sel_nxt;
            sync_cfg_r  <= sync_cfg_nxt;
            sync_flag_r <= sync_flag_nxt;
            irq_stat_r  <= irq_stat_nxt;
            irq_mask_r  <= irq_mask_nxt;
            irq_r       <= irq_nxt;
            rdata_r     <= rdata_nxt;
            lp_active_r <= lp_active_nxt;
        end
    end

    // Byte pusher: channels in order temp, X, Y, Z; high byte first.
    // A strobe during a burst is dropped; a burst lasts at most 8 cycles.
    always_comb begin
        state_nxt = state_r;
        pend_nxt  = pend_r;
        chan_nxt  = chan_r;
        pv_nxt    = 1'b0;
        pb_nxt    = 8'h00;
        for (int i = 0; i < gcfs_pkg::NUM_CHAN; i++) begin
            word_nxt[i] = word_r[i];
        end
        unique case (state_r)
            gcfs_pkg::PUSH_IDLE: begin
                if (tick && (chan_sel_r[7:4] != 4'h0)) begin
                    word_nxt[0] = temp_word;
                    word_nxt[1] = x_rate_word;
                    word_nxt[2] = y_rate_word;
                    word_nxt[3] = z_rate_word;
                    pend_nxt  = chan_sel_r[7:4];
                    chan_nxt  = first_chan(chan_sel_r[7:4]);
                    state_nxt = gcfs_pkg::PUSH_HIGH;
                end
            end
            gcfs_pkg::PUSH_HIGH: begin
                pv_nxt    = 1'b1;
                pb_nxt    = word_r[chan_r][15:8];
                state_nxt = gcfs_pkg::PUSH_LOW;
            end
            gcfs_pkg::PUSH_LOW: begin
                pv_nxt = 1'b1;
                pb_nxt = word_r[chan_r][7:0];
                pend_nxt = pend_r & ~(4'h8 >> chan_r);
                if (pend_nxt != 4'h0) begin
                    chan_nxt  = first_chan(pend_nxt);
                    state_nxt = gcfs_pkg::PUSH_HIGH;
                end else begin
                    state_nxt = gcfs_pkg::PUSH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= gcfs_pkg::PUSH_IDLE;
            pend_r  <= 4'h0;
            chan_r  <= 2'd0;
            pv_r    <= 1'b0;
            pb_r    <= 8'h00;
            for (int i = 0; i < gcfs_pkg::NUM_CHAN; i++) begin
                word_r[i] <= 16'h0000;
            end
        end else begin
            state_r <= state_nxt;
            pend_r  <= pend_nxt;
            chan_r  <= chan_nxt;
            pv_r    <= pv_nxt;
            pb_r    <= pb_nxt;
            for (int i = 0; i < gcfs_pkg::NUM_CHAN; i++) begin
                word_r[i] <= word_nxt[i];
            end
        end
    end

    assign selftest_xyz            = setup_r[gcfs_pkg::X_SELFTEST_BIT:gcfs_pkg::Z_SELFTEST_BIT];
    assign full_scale_range_select = setup_r[gcfs_pkg::FSR_HI:gcfs_pkg::FSR_LO];
    assign filter_bypass_choice    = setup_r[gcfs_pkg::BYPASS_HI:gcfs_pkg::BYPASS_LO];
    assign lowpass_filter_active   = lp_active_r;
    assign lowpass_filter_setting  = lowpass_r[gcfs_pkg::LOWPASS_HI:gcfs_pkg::LOWPASS_LO];
    assign low_power_mode          = lp_cycle_r[gcfs_pkg::LP_CYCLE_BIT];
    // Averages are 2 to the power of this code
    assign averaging_depth_setting = lp_cycle_r[gcfs_pkg::AVG_HI:gcfs_pkg::AVG_LO];
    assign sample_strobe           = tick;
    assign push_valid              = pv_r;
    assign push_byte               = pb_r;
    assign irq                     = irq_r;
    assign reg_rdata               = rdata_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_burst_start;
        state_r == gcfs_pkg::PUSH_IDLE && tick && chan_sel_r[7] && !reg_wr;
    endsequence

    sequence s_temp_pair;
        push_valid && push_byte == $past(temp_word[15:8], 2) ##1
        push_valid && push_byte == $past(temp_word[7:0], 3);
    endsequence

    a_temp_pair_order: assert property (s_burst_start |-> ##2 s_temp_pair)
        else $error("temperature bytes not pushed high then low");
    a_setup_readback: assert property (reg_rd && reg_addr == gcfs_pkg::OFS_RATE_SETUP
        |=> reg_rdata == $past(setup_r))
        else $error("setup register read back wrong");
    a_lp_reset_zero: assert property ($rose(reset_n) |-> !low_power_mode)
        else $error("cycling bit not zero after reset");
    a_lp_no_lowpass: assert property (low_power_mode |-> !lowpass_filter_active)
        else $error("low-pass active in low-power mode");
    a_bypass_gates: assert property (filter_bypass_choice != gcfs_pkg::BYPASS_NONE
        |-> !lowpass_filter_active)
        else $error("low-pass active with bypass set");
    a_flag_sets: assert property (sync_evt |=> sync_flag_r)
        else $error("sync flag not set by event");
    a_flag_read_clr: assert property (reg_rd && reg_addr == gcfs_pkg::OFS_SYNC_FLAG
        && !sync_evt |=> !sync_flag_r ##1 reg_rdata == 8'h00 || sync_flag_r)
        else $error("sync flag not cleared by read");
    a_event_edge: assert property (sync_evt |-> sync_s_r != sync_prev_r)
        else $error("sync event without pin transition");
    a_xyz_burst: assert property (state_r == gcfs_pkg::PUSH_IDLE && tick
        && chan_sel_r[7:4] == 4'h7 && !reg_wr |=> ##1 push_valid [*6] ##1 !push_valid)
        else $error("three-axis burst not six bytes");
    a_irq_follows: assert property (|(irq_stat_r & irq_mask_r) |-> irq)
        else $error("interrupt low with unmasked status");
    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("strobes too close together");
endmodule
`default_nettype wire

// >>> tb/gcfs_host_model.sv
// Purpose: Host side of the register port of the rate sensor bank
// Assumes: One strobe per call, launched just after a rising edge
// Notes:   Idle address and data show the inverse of the last values
`timescale 1ns/1ps
`default_nettype none
module gcfs_host_model (
    input  wire logic       ref_clk,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic is_wr);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= is_wr;
        reg_rd    <= ~is_wr;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        // Stale values must not look valid once the strobe is gone
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_gyro_config_fifo_select_regs.sv
// Purpose: Self-checking bench for the rate sensor configuration bank
// Assumes: Base tick shortened to 10 cycles, so divider 0 strobes every 10
// Notes:   Read data and pushed bytes are checked from queues of notes
`timescale 1ns/1ps
`default_nettype none
module test_gyro_config_fifo_select_regs;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, push_byte;
    logic        reg_wr, reg_rd, frame_sync_pin, sample_strobe, push_valid, irq;
    logic [15:0] temp_word, x_rate_word, y_rate_word, z_rate_word;
    logic [2:0]  selftest_xyz, lowpass_filter_setting, averaging_depth_setting;
    logic [1:0]  full_scale_range_select, filter_bypass_choice;
    logic        lowpass_filter_active, low_power_mode;
    logic [7:0]  rd_q[$];
    logic [7:0]  push_q[$];
    logic        rd_seen = 1'b0;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [7:0]  v;
    logic [7:0]  masks[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'hf0, 8'ha0, 8'h70};
    int          n;

    always #5 ref_clk = ~ref_clk;

    gcfs_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    gcfs_regs #(.BASE_CYC(10)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .frame_sync_pin(frame_sync_pin), .temp_word(temp_word),
        .x_rate_word(x_rate_word), .y_rate_word(y_rate_word), .z_rate_word(z_rate_word),
        .selftest_xyz(selftest_xyz), .full_scale_range_select(full_scale_range_select),
        .filter_bypass_choice(filter_bypass_choice),
        .lowpass_filter_active(lowpass_filter_active),
        .lowpass_filter_setting(lowpass_filter_setting), .low_power_mode(low_power_mode),
        .averaging_depth_setting(averaging_depth_setting), .sample_strobe(sample_strobe),
        .push_valid(push_valid), .push_byte(push_byte), .irq(irq));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        host.xfer(a, 8'h00, 1'b0);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait for the sample strobe; cnt counts the edges passed
    task automatic wait_strobe(output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end while (!sample_strobe && cnt < 200);
    endtask

    task automatic push_burst(input logic [7:0] m);
        logic [15:0] w [4];
        int          k;
        w = '{temp_word, x_rate_word, y_rate_word, z_rate_word};
        wait_strobe(k);
        wr(gcfs_pkg::OFS_CHAN_SEL, m | 8'h0f);
        rd(gcfs_pkg::OFS_CHAN_SEL, m);
        for (k = 0; k < 4; k++) begin
            if (m[7-k]) begin
                push_q.push_back(w[k][15:8]);
                push_q.push_back(w[k][7:0]);
            end
        end
        wait_strobe(k);
        wr(gcfs_pkg::OFS_CHAN_SEL, 8'h00);
        repeat (12) @(posedge ref_clk);
        chk("push_left", 8'h00, 8'(push_q.size()));
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rd_seen && rd_q.size() > 0)
            chk("read_data", rd_q.pop_front(), reg_rdata);
        rd_seen <= reg_rd;
    end

    always @(posedge ref_clk) begin
        if (push_valid === 1'b1) begin
            if (push_q.size() == 0) begin
                bad_count++;
                $display("wrong value push_count expected 0 seen 1");
            end else
                chk("push_byte", push_q.pop_front(), push_byte);
        end
    end

    // Ceiling well above the expected run of about 500 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            end_of_test();
        end
    end

    initial begin
        frame_sync_pin = 1'b0;
        void'($urandom(32'hdeaa));
        temp_word   = 16'($urandom);
        x_rate_word = 16'($urandom);
        y_rate_word = 16'($urandom);
        z_rate_word = 16'($urandom);
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("low_power", 8'h00, 8'(low_power_mode));
        chk("lowpass_active", 8'h01, 8'(lowpass_filter_active));
        rd(gcfs_pkg::OFS_RATE_SETUP, 8'h00);
        rd(gcfs_pkg::OFS_LP_CYCLE, 8'h00);
        rd(gcfs_pkg::OFS_CHAN_SEL, 8'h00);
        rd(gcfs_pkg::OFS_SYNC_FLAG, 8'h00);
        wr(8'h50, 8'hff);
        rd(8'h50, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 4; i++) begin
            v = {3'($urandom), 2'(i), 1'b1, (i == 0) ? 2'b00 : 2'($urandom)};
            wr(gcfs_pkg::OFS_RATE_SETUP, v);
            wr(gcfs_pkg::OFS_LOWPASS, v);
            rd(gcfs_pkg::OFS_RATE_SETUP, v & gcfs_pkg::MSK_RATE_SETUP);
            settle();
            chk("full_scale", 8'(i), 8'(full_scale_range_select));
            chk("selftest", 8'(v[7:5]), 8'(selftest_xyz));
            chk("bypass", 8'(v[1:0]), 8'(filter_bypass_choice));
            chk("lowpass_set", 8'(v[2:0]), 8'(lowpass_filter_setting));
            chk("lowpass_active", 8'(v[1:0] == 2'b00), 8'(lowpass_filter_active));
        end
        $display("test rate setup done");

        wr(gcfs_pkg::OFS_RATE_SETUP, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(gcfs_pkg::OFS_LP_CYCLE, {1'b1, 3'(c), 4'hf});
            rd(gcfs_pkg::OFS_LP_CYCLE, {1'b1, 3'(c), 4'h0});
            settle();
            chk("low_power", 8'h01, 8'(low_power_mode));
            chk("avg_depth", 8'(c), 8'(averaging_depth_setting));
            chk("lowpass_active", 8'h00, 8'(lowpass_filter_active));
        end
        $display("test low power done");

        // Low power stays on so pushing runs with the data path idle
        foreach (masks[i]) push_burst(masks[i]);
        $display("test buffer channels done");

        wr(gcfs_pkg::OFS_DIVIDER, 8'd2);
        wait_strobe(n);
        wait_strobe(n);
        wait_strobe(n);
        chk("strobe_period", 8'd30, 8'(n));
        rd(gcfs_pkg::OFS_IRQ_STAT, 8'h02);
        $display("test divider done");

        wr(gcfs_pkg::OFS_IRQ_MASK, 8'h01);
        wr(gcfs_pkg::OFS_IRQ_STAT, 8'h03);
        wr(gcfs_pkg::OFS_SYNC_CFG, 8'h04);
        rd(gcfs_pkg::OFS_SYNC_FLAG, 8'h00);
        frame_sync_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        chk("irq", 8'h01, 8'(irq));
        rd(gcfs_pkg::OFS_SYNC_FLAG, 8'h80);
        rd(gcfs_pkg::OFS_SYNC_FLAG, 8'h00);
        wr(gcfs_pkg::OFS_IRQ_STAT, 8'h01);
        settle();
        chk("irq", 8'h00, 8'(irq));
        wr(gcfs_pkg::OFS_SYNC_CFG, 8'h0c);
        frame_sync_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(gcfs_pkg::OFS_SYNC_FLAG, 8'h80);
        wr(gcfs_pkg::OFS_IRQ_MASK, 8'h00);
        settle();
        chk("irq", 8'h00, 8'(irq));
        wr(gcfs_pkg::OFS_SYNC_CFG, 8'h00);
        frame_sync_pin <= 1'b1;
        repeat (8) @(posedge ref_clk);
        frame_sync_pin <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rd(gcfs_pkg::OFS_SYNC_FLAG, 8'h00);
        $display("test frame sync done");

        wr(gcfs_pkg::OFS_LP_CYCLE, 8'h00);
        settle();
        chk("lowpass_active", 8'h01, 8'(lowpass_filter_active));
        chk("reads_left", 8'h00, 8'(rd_q.size()));
        $display("test cycling off done");
        end_of_test();
    end
endmodule
`default_nettype wire
